// ### core/pcprb_defines.svh
// Constants for the port control and pin readback block.
// Assumes an 8-bit register port with byte addresses as offsets.
`ifndef PCPRB_DEFINES_SVH
`define PCPRB_DEFINES_SVH

// ==========================================================
// Register offsets
`define PCPRB_P4_DATA 6'h08
`define PCPRB_P4_DIR 6'h09
`define PCPRB_P7_DATA 6'h0e
`define PCPRB_P7_DIR 6'h0f
`define PCPRB_P8_DATA 6'h10
`define PCPRB_P8_DIR 6'h11
`define PCPRB_CTL1 6'h2e
`define PCPRB_CTL2 6'h2f

// ==========================================================
// Control register two fields
`define PCPRB_C2_P4TTL 0
`define PCPRB_C2_P7TTL 1
`define PCPRB_C2_P4OD 2
`define PCPRB_C2_P8SEL 3
`define PCPRB_C2_IRQALT 4
`define PCPRB_C2_TSRC 5
`define PCPRB_C2_NOLOAD 6
`define PCPRB_C2_OBBCLR 7

// Control register one fields
`define PCPRB_C1_PULO 0
`define PCPRB_C1_PUHI 1

// ==========================================================
// Reset values, masks and load values
`define PCPRB_CTL_RST 8'h00
`define PCPRB_DIR_RST 8'h00
`define PCPRB_LATCH_RST 8'h00
`define PCPRB_P4_OD_MASK 8'h5c
`define PCPRB_P4_CLR_MASK 8'h0c
`define PCPRB_T1_LOAD 8'h01
`define PCPRB_PS_LOAD 8'hff

`endif

// ### core/pcprb_pkg.sv
// Types shared by the port control and pin readback block.
// Assumes nothing beyond a SystemVerilog compiler.
package pcprb_pkg;

  // ==========================================================
  // Secondary timer count source
  typedef enum logic [1:0] {
    PCPRB_MAIN_DIV16 = 2'h0,
    PCPRB_SUB_DIV16 = 2'h1,
    PCPRB_SUB_DIRECT = 2'h3
  } pcprb_tsrc_t;

  typedef logic [7:0] pcprb_byte_t;

endpackage : pcprb_pkg

// ### core/pcprb_port_ctrl.sv
// Port control, direction and pin readback logic for ports four, seven and eight.
// Assumes a single-cycle register port on sys_clk; pin inputs are asynchronous,
// stopRelease, lowSpeedMode and obb0SysRead come from logic on sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "pcprb_defines.svh"

// Overview of operation
// - Control-two bits 0 and 1 pick TTL instead of CMOS input levels for upper port-four and low port-seven pins.
// - Control-two bit 2 makes port-four pins 2, 3, 4 and 6 open-drain instead of push-pull.
// - Control-two bit 3 steers port eight's data and direction addresses to the pin readback registers.
// - The pin readback registers return the real pin levels even on output pins.
// - Control-two bit 4 moves external interrupts two, three and four to their second pin choice.
// - Control-two bit 5 picks the secondary timer clock: divided main (or sub in low speed) or the undivided sub clock.
// - With control-two bit 6 low, leaving stop mode loads 01 into timer one and FF into prescaler twelve.
// - With control-two bit 7 high, a system-side read of output buffer zero also clears port-four bits 2 and 3.
// - An open-drain output holding 1 turns its driver off and leaves the pin floating.
// - Control-one bits enable pull-ups on port-three pins 0 to 3 and 4 to 7.
// - Direction bits make a pin an output when 1, reset to 0 and cannot be read back.
// - Data writes load the latch, except port eight's while control-two bit 3 is set; reads give the latch for outputs and the pin for inputs.
// - A read-modify-write takes pin levels for input bits and latch values for output bits.
// - Turning an output into an input leaves its latch unchanged.
module pcprb_port_ctrl
  import pcprb_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic [7:0] p4PinIn,
  input wire logic [7:0] p7PinIn,
  input wire logic [7:0] p8PinIn,
  output logic [7:0] p4PinOut,
  output logic [7:0] p4PinOe,
  output logic [7:0] p7PinOut,
  output logic [7:0] p7PinOe,
  output logic [7:0] p8PinOut,
  output logic [7:0] p8PinOe,
  output logic p4TtlSel,
  output logic p7TtlSel,
  output logic [7:0] p3PullUpEn,
  output logic irqAltSel,
  output pcprb_tsrc_t subTimerSrc,
  input wire logic lowSpeedMode,
  input wire logic stopRelease,
  output logic stopLoadStb,
  output logic [7:0] timerOneLoadVal,
  output logic [7:0] prescalerLoadVal,
  input wire logic obb0SysRead
);

  // ==========================================================
  // Elaboration checks
  if (ADDR_W < 6) begin : gBadAddrW
    $error("ADDR_W must be at least 6");
  end

  localparam int NPORT = 3;
  localparam logic [ADDR_W-1:0] DATA_ADDR [NPORT] = '{
    ADDR_W'(`PCPRB_P4_DATA), ADDR_W'(`PCPRB_P7_DATA), ADDR_W'(`PCPRB_P8_DATA)};
  localparam logic [ADDR_W-1:0] DIR_ADDR [NPORT] = '{
    ADDR_W'(`PCPRB_P4_DIR), ADDR_W'(`PCPRB_P7_DIR), ADDR_W'(`PCPRB_P8_DIR)};

  // ==========================================================
  // Pin input synchronisers
  pcprb_byte_t pinRaw [NPORT];
  pcprb_byte_t pinMeta_reg [NPORT];
  pcprb_byte_t pinSync_reg [NPORT];

  assign pinRaw[0] = p4PinIn;
  assign pinRaw[1] = p7PinIn;
  assign pinRaw[2] = p8PinIn;

  for (genvar g = 0; g < NPORT; g++) begin : gSync
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        pinMeta_reg[g] <= 8'h00;
        pinSync_reg[g] <= 8'h00;
      end else begin
        pinMeta_reg[g] <= pinRaw[g];
        pinSync_reg[g] <= pinMeta_reg[g];
      end
    end
  end

  // ==========================================================
  // Register file and pin drivers
  pcprb_byte_t ctl1_reg, ctl1_next;
  pcprb_byte_t ctl2_reg, ctl2_next;
  pcprb_byte_t latch_reg [NPORT];
  pcprb_byte_t latch_next [NPORT];
  pcprb_byte_t dir_reg [NPORT];
  pcprb_byte_t dir_next [NPORT];
  pcprb_byte_t pinOut_reg [NPORT];
  pcprb_byte_t pinOut_next [NPORT];
  pcprb_byte_t pinOe_reg [NPORT];
  pcprb_byte_t pinOe_next [NPORT];
  pcprb_byte_t rdData_reg, rdData_next;
  logic p8Remap;
  logic blocked;

  always_comb begin
    ctl1_next = ctl1_reg;
    ctl2_next = ctl2_reg;
    latch_next = latch_reg;
    dir_next = dir_reg;
    rdData_next = 8'h00;
    blocked = 1'b0;
    p8Remap = ctl2_reg[`PCPRB_C2_P8SEL];
    // Hardware clear first so a same-cycle software write takes priority
    if (ctl2_reg[`PCPRB_C2_OBBCLR] && obb0SysRead) begin
      latch_next[0] = latch_reg[0] & ~`PCPRB_P4_CLR_MASK;
    end
    for (int p = 0; p < NPORT; p++) begin
      blocked = (p == NPORT - 1) && p8Remap;
      if (regWrStb && !blocked && regAddr == DATA_ADDR[p]) begin
        latch_next[p] = regWrData;
      end
      if (regWrStb && !blocked && regAddr == DIR_ADDR[p]) begin
        dir_next[p] = regWrData;
      end
      // Input bits show the pin, output bits the latch, so RMW rewrites both
      if (regRdStb && !blocked && regAddr == DATA_ADDR[p]) begin
        rdData_next = (dir_reg[p] & latch_reg[p]) | (~dir_reg[p] & pinSync_reg[p]);
      end
    end
    if (regRdStb && p8Remap && regAddr == DATA_ADDR[NPORT-1]) begin
      rdData_next = pinSync_reg[0];
    end
    if (regRdStb && p8Remap && regAddr == DIR_ADDR[NPORT-1]) begin
      rdData_next = pinSync_reg[1];
    end
    if (regWrStb && regAddr == ADDR_W'(`PCPRB_CTL1)) begin
      ctl1_next = regWrData;
    end
    if (regWrStb && regAddr == ADDR_W'(`PCPRB_CTL2)) begin
      ctl2_next = regWrData;
    end
    if (regRdStb && regAddr == ADDR_W'(`PCPRB_CTL1)) begin
      rdData_next = ctl1_reg;
    end
    if (regRdStb && regAddr == ADDR_W'(`PCPRB_CTL2)) begin
      rdData_next = ctl2_reg;
    end
    // Drivers follow the next state so pins move with the register write
    for (int p = 0; p < NPORT; p++) begin
      pinOut_next[p] = latch_next[p];
      pinOe_next[p] = dir_next[p];
    end
    if (ctl2_next[`PCPRB_C2_P4OD]) begin
      pinOe_next[0] = dir_next[0] & ~(`PCPRB_P4_OD_MASK & latch_next[0]);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl1_reg <= `PCPRB_CTL_RST;
      ctl2_reg <= `PCPRB_CTL_RST;
      rdData_reg <= 8'h00;
      for (int p = 0; p < NPORT; p++) begin
        latch_reg[p] <= `PCPRB_LATCH_RST;
        dir_reg[p] <= `PCPRB_DIR_RST;
        pinOut_reg[p] <= `PCPRB_LATCH_RST;
        pinOe_reg[p] <= `PCPRB_DIR_RST;
      end
    end else begin
      ctl1_reg <= ctl1_next;
      ctl2_reg <= ctl2_next;
      rdData_reg <= rdData_next;
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      pinOut_reg <= pinOut_next;
      pinOe_reg <= pinOe_next;
    end
  end

  // ==========================================================
  // Mode outputs and stop-release load
  logic p4Ttl_reg, p4Ttl_next;
  logic p7Ttl_reg, p7Ttl_next;
  logic irqAlt_reg, irqAlt_next;
  pcprb_byte_t pullUp_reg, pullUp_next;
  pcprb_tsrc_t tsrc_reg, tsrc_next;
  logic load_reg, load_next;
  pcprb_byte_t loadT1_reg, loadT1_next;
  pcprb_byte_t loadPs_reg, loadPs_next;

  always_comb begin
    p4Ttl_next = ctl2_next[`PCPRB_C2_P4TTL];
    p7Ttl_next = ctl2_next[`PCPRB_C2_P7TTL];
    irqAlt_next = ctl2_next[`PCPRB_C2_IRQALT];
    pullUp_next = {{4{ctl1_next[`PCPRB_C1_PUHI]}}, {4{ctl1_next[`PCPRB_C1_PULO]}}};
    if (ctl2_next[`PCPRB_C2_TSRC]) begin
      tsrc_next = PCPRB_SUB_DIRECT;
    end else if (lowSpeedMode) begin
      tsrc_next = PCPRB_SUB_DIV16;
    end else begin
      tsrc_next = PCPRB_MAIN_DIV16;
    end
    load_next = stopRelease && !ctl2_reg[`PCPRB_C2_NOLOAD];
    loadT1_next = load_next ? `PCPRB_T1_LOAD : 8'h00;
    loadPs_next = load_next ? `PCPRB_PS_LOAD : 8'h00;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      p4Ttl_reg <= 1'b0;
      p7Ttl_reg <= 1'b0;
      irqAlt_reg <= 1'b0;
      pullUp_reg <= 8'h00;
      tsrc_reg <= PCPRB_MAIN_DIV16;
      load_reg <= 1'b0;
      loadT1_reg <= 8'h00;
      loadPs_reg <= 8'h00;
    end else begin
      p4Ttl_reg <= p4Ttl_next;
      p7Ttl_reg <= p7Ttl_next;
      irqAlt_reg <= irqAlt_next;
      pullUp_reg <= pullUp_next;
      tsrc_reg <= tsrc_next;
      load_reg <= load_next;
      loadT1_reg <= loadT1_next;
      loadPs_reg <= loadPs_next;
    end
  end

  assign regRdData = rdData_reg;
  assign p4PinOut = pinOut_reg[0];
  assign p4PinOe = pinOe_reg[0];
  assign p7PinOut = pinOut_reg[1];
  assign p7PinOe = pinOe_reg[1];
  assign p8PinOut = pinOut_reg[2];
  assign p8PinOe = pinOe_reg[2];
  assign p4TtlSel = p4Ttl_reg;
  assign p7TtlSel = p7Ttl_reg;
  assign p3PullUpEn = pullUp_reg;
  assign irqAltSel = irqAlt_reg;
  assign subTimerSrc = tsrc_reg;
  assign stopLoadStb = load_reg;
  assign timerOneLoadVal = loadT1_reg;
  assign prescalerLoadVal = loadPs_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_dir_write_only: assert property (
    regRdStb && regAddr == DIR_ADDR[0] |=> regRdData == 8'h00)
    else $error("direction register read back nonzero");
  a_remap_pin_read: assert property (
    regRdStb && p8Remap && regAddr == DATA_ADDR[2] |=> regRdData == $past(pinSync_reg[0]))
    else $error("readback does not show port four pins");
  a_remap_no_write: assert property (
    regWrStb && p8Remap && regAddr == DIR_ADDR[2] |=> dir_reg[2] == $past(dir_reg[2]))
    else $error("readback write altered port eight direction");
  a_latch_load: assert property (
    regWrStb && regAddr == DATA_ADDR[1] |=> latch_reg[1] == $past(regWrData) && p7PinOut == $past(regWrData))
    else $error("data write did not reach latch and pin");
  a_dir_keeps_latch: assert property (
    regWrStb && regAddr == DIR_ADDR[1] |=> latch_reg[1] == $past(latch_reg[1]))
    else $error("direction write changed latch");
  a_od_release: assert property (
    ctl2_reg[`PCPRB_C2_P4OD] && p4PinOut[2] |-> !p4PinOe[2])
    else $error("open-drain pin driven while latch high");
  a_cmos_drive: assert property (
    !ctl2_reg[`PCPRB_C2_P4OD] |-> p4PinOe == dir_reg[0])
    else $error("push-pull enable differs from direction");
  a_stop_load: assert property (
    stopRelease && !ctl2_reg[`PCPRB_C2_NOLOAD]
    |=> stopLoadStb && timerOneLoadVal == `PCPRB_T1_LOAD && prescalerLoadVal == `PCPRB_PS_LOAD)
    else $error("stop release load missing");
  a_stop_noload: assert property (
    stopRelease && ctl2_reg[`PCPRB_C2_NOLOAD] |=> !stopLoadStb)
    else $error("automatic load despite disable");
  a_obb_clear: assert property (
    obb0SysRead && ctl2_reg[`PCPRB_C2_OBBCLR] && !regWrStb |=> (latch_reg[0] & `PCPRB_P4_CLR_MASK) == 8'h00)
    else $error("output buffer read did not clear bits");
  a_ttl_irq_sel: assert property (
    regWrStb && regAddr == ADDR_W'(`PCPRB_CTL2)
    |=> p4TtlSel == $past(regWrData[0]) && p7TtlSel == $past(regWrData[1]) && irqAltSel == $past(regWrData[4]))
    else $error("mode outputs did not follow control write");
  a_pullup_sel: assert property (
    regWrStb && regAddr == ADDR_W'(`PCPRB_CTL1) |=> p3PullUpEn == {{4{$past(regWrData[1])}}, {4{$past(regWrData[0])}}})
    else $error("pull-up enables wrong");
  a_tsrc_sel: assert property (
    !ctl2_reg[`PCPRB_C2_TSRC] && !$past(ctl2_reg[`PCPRB_C2_TSRC]) && $past(lowSpeedMode) |-> subTimerSrc == PCPRB_SUB_DIV16)
    else $error("timer source not sub divided in low speed");

  c_remap_read: cover property (regRdStb && p8Remap && regAddr == DIR_ADDR[2]);
  c_od_float: cover property (p4PinOut[3] && !p4PinOe[3] && dir_reg[0][3]);
  c_stop_load: cover property (stopLoadStb);
  c_obb_clear: cover property (obb0SysRead && ctl2_reg[`PCPRB_C2_OBBCLR] && latch_reg[0][2]);

endmodule : pcprb_port_ctrl
`default_nettype wire

// ### verif/pcprb_pin_model.sv
// Board-side model of one 8-bit port: resolves every pin level.
// Assumes enables are high while a party drives; the board holds pull-ups on all pins.
`timescale 1ns/10ps
`default_nettype none
module pcprb_pin_model (
  input wire logic [7:0] devOut,
  input wire logic [7:0] devOe,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  output logic [7:0] pinLevel
);
  // ==========================================================
  // Pin resolution
  // A released pin goes to the pull-up, never to a stale value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinLevel[i] = devOe[i] ? devOut[i] : (extEn[i] ? extVal[i] : 1'b1);
    end
  end
endmodule : pcprb_pin_model
`default_nettype wire

// ### verif/pcprb_port_ctrl_tb.sv
// Self-checking bench for the port control and pin readback block.
// Assumes pcprb_pkg is compiled first and pcprb_defines.svh is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "pcprb_defines.svh"
module pcprb_port_ctrl_tb
  import pcprb_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] pin [3];
  logic [7:0] dOut [3];
  logic [7:0] dOe [3];
  logic [7:0] extVal [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] extEn [3] = '{8'h00, 8'h00, 8'h00};
  logic p4TtlSel, p7TtlSel, irqAltSel, stopLoadStb;
  logic [7:0] p3PullUpEn, timerOneLoadVal, prescalerLoadVal;
  pcprb_tsrc_t subTimerSrc;
  logic lowSpeedMode = 1'b0;
  logic stopRelease = 1'b0;
  logic obb0SysRead = 1'b0;
  int errors = 0;
  int checked = 0;

  always #12.5 sys_clk = ~sys_clk;

  pcprb_port_ctrl uut (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .p4PinIn(pin[0]), .p7PinIn(pin[1]), .p8PinIn(pin[2]), .p4PinOut(dOut[0]),
    .p4PinOe(dOe[0]), .p7PinOut(dOut[1]), .p7PinOe(dOe[1]), .p8PinOut(dOut[2]),
    .p8PinOe(dOe[2]), .p4TtlSel(p4TtlSel), .p7TtlSel(p7TtlSel), .p3PullUpEn(p3PullUpEn),
    .irqAltSel(irqAltSel), .subTimerSrc(subTimerSrc), .lowSpeedMode(lowSpeedMode),
    .stopRelease(stopRelease), .stopLoadStb(stopLoadStb), .timerOneLoadVal(timerOneLoadVal),
    .prescalerLoadVal(prescalerLoadVal), .obb0SysRead(obb0SysRead));

  for (genvar g = 0; g < 3; g++) begin : gPins
    pcprb_pin_model board (.devOut(dOut[g]), .devOe(dOe[g]), .extVal(extVal[g]),
      .extEn(extEn[g]), .pinLevel(pin[g]));
  end

  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string msg);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData, exp, msg);
  endtask : rd

  // Pins pass two sync flops, so give them a few edges to settle
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic pulse(input bit obb);
    @(posedge sys_clk);
    if (obb) begin
      obb0SysRead <= 1'b1;
    end else begin
      stopRelease <= 1'b1;
    end
    @(posedge sys_clk);
    obb0SysRead <= 1'b0;
    stopRelease <= 1'b0;
    #1;
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(`PCPRB_CTL2, 8'h00, "ctl2 reset");
    rd(`PCPRB_CTL1, 8'h00, "ctl1 reset");
    chk(dOe[0] | dOe[1] | dOe[2], 8'h00, "oe reset");
    rd(6'h3f, 8'h00, "unmapped read");
  endtask : t_reset

  task automatic t_modes();
    wr(`PCPRB_CTL2, 8'h33);
    chk({p4TtlSel, p7TtlSel, irqAltSel}, 8'h07, "ttl irq sel");
    chk(8'(subTimerSrc), 8'(PCPRB_SUB_DIRECT), "tsrc direct");
    rd(`PCPRB_CTL2, 8'h33, "ctl2 readback");
    wr(`PCPRB_CTL2, 8'h00);
    @(posedge sys_clk);
    lowSpeedMode <= 1'b1;
    settle();
    chk(8'(subTimerSrc), 8'(PCPRB_SUB_DIV16), "tsrc low speed");
    @(posedge sys_clk);
    lowSpeedMode <= 1'b0;
    settle();
    chk(8'(subTimerSrc), 8'(PCPRB_MAIN_DIV16), "tsrc main");
    chk({p4TtlSel, p7TtlSel, irqAltSel}, 8'h00, "ttl irq clear");
    wr(`PCPRB_CTL1, 8'h01);
    chk(p3PullUpEn, 8'h0f, "pull-up low");
    wr(`PCPRB_CTL1, 8'h02);
    chk(p3PullUpEn, 8'hf0, "pull-up high");
  endtask : t_modes

  task automatic t_ports();
    wr(`PCPRB_P4_DIR, 8'hf0);
    wr(`PCPRB_P4_DATA, 8'ha5);
    chk(dOut[0], 8'ha5, "p4 latch");
    chk(dOe[0], 8'hf0, "p4 dir");
    extVal[0] <= 8'h06;
    extEn[0] <= 8'h0f;
    settle();
    rd(`PCPRB_P4_DATA, 8'ha6, "p4 mixed read");
    // Bit set done as read-modify-write: input bits pick up their pin levels
    wr(`PCPRB_P4_DATA, 8'hae);
    chk(dOut[0], 8'hae, "rmw rewrote input bits");
    rd(`PCPRB_P4_DIR, 8'h00, "dir write only");
    wr(`PCPRB_P4_DIR, 8'h00);
    chk(dOut[0], 8'hae, "latch kept");
    settle();
    rd(`PCPRB_P4_DATA, 8'hf6, "p4 all inputs");
    extEn[0] <= 8'h00;
    wr(`PCPRB_P7_DIR, 8'h0f);
    wr(`PCPRB_P7_DATA, 8'h3c);
    chk(dOe[1], 8'h0f, "p7 dir");
    chk(dOut[1], 8'h3c, "p7 latch");
  endtask : t_ports

  task automatic t_opendrain();
    wr(`PCPRB_CTL2, 8'h0c);
    wr(`PCPRB_P4_DIR, 8'hff);
    wr(`PCPRB_P4_DATA, 8'ha5);
    chk(dOe[0], 8'hfb, "od driver off");
    extVal[0] <= 8'h00;
    extEn[0] <= 8'h04;
    settle();
    rd(`PCPRB_P8_DATA, 8'ha1, "od pin pulled low");
    wr(`PCPRB_CTL2, 8'h08);
    chk(dOe[0], 8'hff, "push-pull");
    extEn[0] <= 8'h00;
  endtask : t_opendrain

  task automatic t_readback();
    extVal[1] <= 8'h50;
    extEn[1] <= 8'hf0;
    settle();
    rd(`PCPRB_P8_DIR, 8'h5c, "p7 pins");
    wr(`PCPRB_P8_DATA, 8'h77);
    wr(`PCPRB_P8_DIR, 8'hff);
    chk(dOut[2] | dOe[2], 8'h00, "readback write ignored");
    chk(dOut[0], 8'ha5, "p4 latch untouched");
    wr(`PCPRB_CTL2, 8'h00);
    wr(`PCPRB_P8_DIR, 8'hff);
    wr(`PCPRB_P8_DATA, 8'h5a);
    rd(`PCPRB_P8_DATA, 8'h5a, "p8 restored");
    chk(dOut[2], 8'h5a, "p8 pins driven");
  endtask : t_readback

  task automatic t_stop();
    pulse(1'b0);
    chk({7'h00, stopLoadStb}, 8'h01, "stop load");
    chk(timerOneLoadVal, `PCPRB_T1_LOAD, "timer one load");
    chk(prescalerLoadVal, `PCPRB_PS_LOAD, "prescaler load");
    @(posedge sys_clk);
    #1;
    chk({7'h00, stopLoadStb}, 8'h00, "load one cycle");
    wr(`PCPRB_CTL2, 8'h40);
    pulse(1'b0);
    chk({7'h00, stopLoadStb}, 8'h00, "no auto load");
  endtask : t_stop

  task automatic t_obb();
    wr(`PCPRB_CTL2, 8'h80);
    wr(`PCPRB_P4_DATA, 8'hff);
    pulse(1'b1);
    chk(dOut[0], 8'hf3, "obb clear");
    wr(`PCPRB_CTL2, 8'h00);
    wr(`PCPRB_P4_DATA, 8'hff);
    pulse(1'b1);
    chk(dOut[0], 8'hff, "software clear only");
  endtask : t_obb

  task automatic close_out();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_modes();
    t_ports();
    t_opendrain();
    t_readback();
    t_stop();
    t_obb();
    close_out();
  end

  // The whole run needs under two hundred cycles
  initial begin
    #(4000 * 25);
    errors++;
    close_out();
  end
endmodule : pcprb_port_ctrl_tb
`default_nettype wire
